// file: logic/xie_exec.v
// Decode and execute of the extended instruction set
// Contract
// - Extension inactive unless enable bit set
// - Enabled core recognises four extra opcodes
// - Add literal to pointer zero to two
// - Selector three adds to frame pointer
// - Add-return then pops return stack into PC
// - Add-return takes two cycles, second idle
// - Add and subtract both have return forms
// - Indirect call pushes PC plus two
// - Working register overwrites PC low byte
// - Latches load PC high and upper bytes
// - Indirect call takes two cycles, second idle
// - Call leaves W, status, bank untouched
// - Subtract literal, selector three returns
// - Access operand at most 5Fh is frame-relative
`include "xie_defs.vh"
module xie_exec #(
   parameter PCW = 21,
   parameter AW  = 12
) (
   clk_sys,
   reset,
   clk_en,
   extension_enable_config_bit,
   instr,
   instr_valid,
   pc,
   working_register,
   pc_high_latch,
   pc_upper_latch,
   std_access_bit,
   std_file_addr,
   std_eff_addr,
   ext_hit,
   busy,
   ptr0,
   ptr1,
   stack_frame_pointer,
   push_req,
   push_data,
   pop_req,
   pc_load,
   pc_load_val,
   mem_rd_addr,
   mem_rd_en,
   mem_rd_data,
   mem_wr_addr,
   mem_wr_en,
   mem_wr_data,
   fetch_flush
);
   input  wire           clk_sys;
   input  wire           reset;
   input  wire           clk_en;
   input  wire           extension_enable_config_bit;
   input  wire [15:0]    instr;
   input  wire           instr_valid;
   input  wire [PCW-1:0] pc;
   input  wire [7:0]     working_register;
   input  wire [7:0]     pc_high_latch;
   input  wire [4:0]     pc_upper_latch;
   input  wire           std_access_bit;
   input  wire [7:0]     std_file_addr;
   output wire [AW-1:0]  std_eff_addr;
   output wire           ext_hit;
   output wire           busy;
   output reg  [AW-1:0]  ptr0;
   output reg  [AW-1:0]  ptr1;
   output reg  [AW-1:0]  stack_frame_pointer;
   output reg            push_req;
   output reg  [PCW-1:0] push_data;
   output reg            pop_req;
   output reg            pc_load;
   output reg  [PCW-1:0] pc_load_val;
   output reg  [AW-1:0]  mem_rd_addr;
   output reg            mem_rd_en;
   input  wire [7:0]     mem_rd_data;
   output reg  [AW-1:0]  mem_wr_addr;
   output reg            mem_wr_en;
   output reg  [7:0]     mem_wr_data;
   output reg            fetch_flush;

   localparam S_IDLE = 3'b001;
   localparam S_NOP  = 3'b010;
   localparam S_MOVE = 3'b100;

   reg  [2:0]    state_r;
   reg  [2:0]    state_nxt;
   reg  [AW-1:0] src_addr_r;
   reg           mov_ss_r;

   wire          go;
   wire          is_call_through_working_register;
   wire          is_addp;
   wire          is_subp;
   wire          is_movs;
   wire [1:0]    sel;
   wire [5:0]    lit;
   wire [AW-1:0] sel_ptr;
   wire [AW-1:0] alu_out;
   wire [AW-1:0] dst_addr;
   wire          dst_bad;

   function [AW-1:0] frame_off;
      input [AW-1:0] base;
      input [6:0]    off;
      begin
         frame_off = base + {{(AW-7){1'b0}}, off};
      end
   endfunction

   function is_ind;
      input [AW-1:0] a;
      begin
         is_ind = (a >= `XIE_IND_LO) && (a <= `XIE_IND_HI);
      end
   endfunction

   // Decoding only in idle; word two of a move is consumed in S_MOVE
   assign go       = clk_en && instr_valid && (state_r == S_IDLE)
                     && extension_enable_config_bit;
   assign is_call_through_working_register = (instr == `XIE_OP_CALL_THROUGH_WORKING_REGISTER);
   assign is_addp  = (instr[15:8] == `XIE_OP_ADDP);
   assign is_subp  = (instr[15:8] == `XIE_OP_SUBP);
   assign is_movs  = (instr[15:8] == `XIE_OP_MOVS);
   assign ext_hit  = extension_enable_config_bit
                     && (is_call_through_working_register || is_addp || is_subp || is_movs);
   assign busy     = (state_r != S_IDLE);
   assign sel      = instr[7:6];
   assign lit      = instr[5:0];
   assign sel_ptr  = (sel == 2'h0) ? ptr0 : (sel == 2'h1) ? ptr1 : stack_frame_pointer;

   // Indexed literal offset applies only with extension on and access bit clear
   assign std_eff_addr = (extension_enable_config_bit && !std_access_bit
                          && std_file_addr <= `XIE_IDX_LIMIT)
                         ? frame_off(stack_frame_pointer, std_file_addr[6:0])
                         : {{(AW-8){1'b0}}, std_file_addr};

   xie_ptr_alu #(
      .PW (AW)
   ) u_alu (
      .ptr_in  (sel_ptr),
      .lit     (lit),
      .sub     (is_subp),
      .ptr_out (alu_out)
   );

   assign dst_addr = mov_ss_r ? frame_off(stack_frame_pointer, instr[6:0])
                              : instr[AW-1:0];
   assign dst_bad  = (dst_addr == `XIE_ADDR_PCL) || (dst_addr == `XIE_ADDR_RETURN_STACK_TOP_LOW)
                     || (dst_addr == `XIE_ADDR_RETURN_STACK_TOP_HIGH) || (dst_addr == `XIE_ADDR_RETURN_STACK_TOP_UPPER);

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
         begin
            if (go && (is_call_through_working_register || ((is_addp || is_subp) && sel == `XIE_SEL_FRAME)))
               state_nxt = S_NOP;
            else if (go && is_movs)
               state_nxt = S_MOVE;
         end
         S_NOP:
            if (clk_en)
               state_nxt = S_IDLE;
         S_MOVE:
            if (clk_en && instr_valid)
               state_nxt = S_IDLE;
         default:
            state_nxt = S_IDLE;
      endcase
   end

   always @(posedge clk_sys)
   begin
      if (reset)
      begin
         state_r             <= S_IDLE;
         src_addr_r          <= `XIE_PTR_RST;
         mov_ss_r            <= 1'b0;
         ptr0                <= `XIE_PTR_RST;
         ptr1                <= `XIE_PTR_RST;
         stack_frame_pointer <= `XIE_PTR_RST;
         push_req            <= 1'b0;
         push_data           <= {PCW{1'b0}};
         pop_req             <= 1'b0;
         pc_load             <= 1'b0;
         pc_load_val         <= {PCW{1'b0}};
         mem_rd_addr         <= `XIE_PTR_RST;
         mem_rd_en           <= 1'b0;
         mem_wr_addr         <= `XIE_PTR_RST;
         mem_wr_en           <= 1'b0;
         mem_wr_data         <= 8'h00;
         fetch_flush         <= 1'b0;
      end
      else if (clk_en)
      begin
         state_r     <= state_nxt;
         push_req    <= 1'b0;
         pop_req     <= 1'b0;
         pc_load     <= 1'b0;
         mem_rd_en   <= 1'b0;
         mem_wr_en   <= 1'b0;
         fetch_flush <= 1'b0;
         // Status, W and bank select are never driven from here
         if (go && (is_addp || is_subp))
         begin
            case (sel)
               2'h0:    ptr0 <= alu_out;
               2'h1:    ptr1 <= alu_out;
               2'h2:    stack_frame_pointer <= alu_out;
               default:
               begin
                  stack_frame_pointer <= alu_out;
                  pop_req     <= 1'b1;
                  fetch_flush <= 1'b1;
               end
            endcase
         end
         else if (go && is_call_through_working_register)
         begin
            push_req    <= 1'b1;
            push_data   <= pc + `XIE_PC_STEP;
            pc_load     <= 1'b1;
            pc_load_val <= {pc_upper_latch, pc_high_latch, working_register};
            fetch_flush <= 1'b1;
         end
         else if (go && is_movs)
         begin
            mov_ss_r    <= instr[7];
            src_addr_r  <= frame_off(stack_frame_pointer, instr[6:0]);
            mem_rd_addr <= frame_off(stack_frame_pointer, instr[6:0]);
            mem_rd_en   <= !is_ind(frame_off(stack_frame_pointer, instr[6:0]));
         end
         else if (state_r == S_MOVE && instr_valid)
         begin
            // A barred destination drops the write rather than corrupt the PC
            mem_wr_addr <= dst_addr;
            mem_wr_en   <= !dst_bad;
            mem_wr_data <= is_ind(src_addr_r) ? 8'h00 : mem_rd_data;
         end
      end
   end
endmodule // xie_exec

// file: logic/xie_defs.vh
// Constants for the extended instruction execution unit
`ifndef XIE_DEFS_VH
`define XIE_DEFS_VH
`define XIE_OP_CALL_THROUGH_WORKING_REGISTER     16'h0014
`define XIE_OP_ADDP      8'he8
`define XIE_OP_SUBP      8'he9
`define XIE_OP_MOVS      8'heb
`define XIE_OP_WORD2     4'hf
`define XIE_SEL_FRAME    2'h3
`define XIE_IDX_LIMIT    8'h5f
`define XIE_PC_STEP      21'h000002
`define XIE_ADDR_PCL     12'hff9
`define XIE_ADDR_RETURN_STACK_TOP_LOW    12'hffd
`define XIE_ADDR_RETURN_STACK_TOP_HIGH    12'hffe
`define XIE_ADDR_RETURN_STACK_TOP_UPPER    12'hfff
`define XIE_IND_LO       12'hfe3
`define XIE_IND_HI       12'hfef
`define XIE_PTR_RST      12'h000
`endif

// file: logic/xie_ptr_alu.v
// Pointer add and subtract with a zero-extended 6-bit literal
module xie_ptr_alu #(
   parameter PW = 12
) (
   ptr_in,
   lit,
   sub,
   ptr_out
);
   input  wire [PW-1:0] ptr_in;
   input  wire [5:0]    lit;
   input  wire          sub;
   output wire [PW-1:0] ptr_out;

   wire [PW-1:0] lit_ext;

   assign lit_ext = {{(PW-6){1'b0}}, lit};
   assign ptr_out = sub ? ptr_in - lit_ext : ptr_in + lit_ext;
endmodule // xie_ptr_alu

// file: dv/xie_exec_chk.sv
// Checker for the extended instruction unit ports
module xie_exec_chk #(
   parameter PCW = 21,
   parameter AW  = 12
) (
   input logic           clk_sys,
   input logic           reset,
   input logic           clk_en,
   input logic           extension_enable_config_bit,
   input logic [15:0]    instr,
   input logic           instr_valid,
   input logic [PCW-1:0] pc,
   input logic           std_access_bit,
   input logic [7:0]     std_file_addr,
   input logic [AW-1:0]  std_eff_addr,
   input logic           ext_hit,
   input logic           busy,
   input logic [AW-1:0]  ptr1,
   input logic [AW-1:0]  stack_frame_pointer,
   input logic           push_req,
   input logic [PCW-1:0] push_data,
   input logic           pop_req,
   input logic           mem_wr_en,
   input logic [AW-1:0]  mem_wr_addr
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   wire          take = clk_en && instr_valid && extension_enable_config_bit && !busy;
   wire [AW-1:0] k    = {{(AW-6){1'b0}}, instr[5:0]};
   a_add_ptr:
   assert property (take && instr[15:6] == 10'h3a1 |=> ptr1 == $past(ptr1) + $past(k))
      else $error("pointer add wrong");
   a_add_ret:
   assert property (take && instr[15:6] == 10'h3a3 |=> pop_req && busy
      && stack_frame_pointer == $past(stack_frame_pointer) + $past(k))
      else $error("add and return wrong");
   a_sub_ret:
   assert property (take && instr[15:6] == 10'h3a7 |=> pop_req && busy
      && stack_frame_pointer == $past(stack_frame_pointer) - $past(k))
      else $error("subtract and return wrong");
   a_call_push:
   assert property (take && instr == 16'h0014 |=> push_req && push_data == $past(pc) + 2)
      else $error("call push wrong");
   a_ret_idle:
   assert property (pop_req |-> busy ##1 !pop_req && !busy)
      else $error("return second cycle not idle");
   a_call_idle:
   assert property (push_req |-> busy ##1 !push_req && !busy)
      else $error("call second cycle not idle");
   a_ext_off:
   assert property (!extension_enable_config_bit |-> !ext_hit
      && std_eff_addr == {4'h0, std_file_addr})
      else $error("extension active while off");
   a_frame_idx:
   assert property (extension_enable_config_bit && !std_access_bit && std_file_addr <= 8'h5f
      |-> std_eff_addr == stack_frame_pointer + std_file_addr)
      else $error("frame offset address wrong");
   a_en_freeze:
   assert property (!clk_en |=> $stable(ptr1) && $stable(stack_frame_pointer))
      else $error("pointer moved while clock enable low");
   a_no_barred:
   assert property (mem_wr_en |-> !(mem_wr_addr inside {12'hff9, 12'hffd, 12'hffe, 12'hfff}))
      else $error("write to barred address");
endmodule // xie_exec_chk

bind xie_exec xie_exec_chk #(.PCW(PCW), .AW(AW)) u_chk (.*);

// file: dv/xie_exec_tb_top.sv
// Self-checking bench for the extended instruction unit
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module xie_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 0, reset = 1, clk_en = 1, instr_valid = 0;
   logic        extension_enable_config_bit = 1, std_access_bit = 0;
   logic [15:0] instr = 16'h0000;
   logic [20:0] pc = 21'h000100, push_data, pc_load_val;
   logic [7:0]  working_register = 8'ha5, pc_high_latch = 8'h12, std_file_addr = 8'h00;
   logic [7:0]  mem_rd_data = 8'h5a, mem_wr_data;
   logic [4:0]  pc_upper_latch = 5'h1f;
   logic [11:0] std_eff_addr, ptr0, ptr1, stack_frame_pointer, mem_rd_addr, mem_wr_addr;
   logic        ext_hit, busy, push_req, pop_req, pc_load, mem_rd_en, mem_wr_en, fetch_flush;
   int          error_cnt = 0, n_tests = 0;
   xie_exec uut (.*);
   always #5 clk_sys = ~clk_sys;
   // Word is taken one edge after it appears; outputs read just after that edge
   task automatic issue(input logic [15:0] w);
      @(posedge clk_sys);
      instr <= w;
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
   endtask
   task automatic t_ptr;
      issue(16'he87f);
      `CHK("ptr1", 12'h03f, ptr1)
      issue(16'he901);
      `CHK("ptr0", 12'hfff, ptr0)
      issue(16'he882);
      `CHK("frame", 12'h002, stack_frame_pointer)
      // Enable low: the add must not land
      @(posedge clk_sys);
      clk_en <= 1'b0;
      issue(16'he841);
      `CHK("frozen", 12'h03f, ptr1)
      @(posedge clk_sys);
      clk_en <= 1'b1;
   endtask
   task automatic t_ret;
      issue(16'he8ff);
      `CHK("add ret", {3'b111, 12'h041}, {pop_req, fetch_flush, busy, stack_frame_pointer})
      @(posedge clk_sys);
      #1;
      `CHK("ret idle", 2'b00, {pop_req, busy})
      issue(16'he9c1);
      `CHK("sub ret", {3'b111, 12'h040}, {pop_req, fetch_flush, busy, stack_frame_pointer})
   endtask
   task automatic t_call;
      @(posedge clk_sys);
      working_register <= 8'h3c;
      issue(16'h0014);
      `CHK("push", 21'h000102, push_data)
      `CHK("pcl", 8'h3c, pc_load_val[7:0])
      `CHK("target", {5'h1f, 8'h12, 8'h3c}, pc_load_val)
      `CHK("call flags", 4'hf, {push_req, pc_load, fetch_flush, busy})
      @(posedge clk_sys);
      #1;
      `CHK("call idle", 2'b00, {push_req, busy})
      // Off: the same word must be ignored and offsets read as plain addresses
      @(posedge clk_sys);
      extension_enable_config_bit <= 1'b0;
      std_file_addr <= 8'h5f;
      issue(16'h0014);
      `CHK("off call", 2'b00, {push_req, ext_hit})
      `CHK("off addr", 12'h05f, std_eff_addr)
      @(posedge clk_sys);
      extension_enable_config_bit <= 1'b1;
      #1;
      `CHK("idx addr", 12'h09f, std_eff_addr)
      @(posedge clk_sys);
      std_file_addr <= 8'h60;
      #1;
      `CHK("abs addr", 12'h060, std_eff_addr)
   endtask
   task automatic t_move;
      issue(16'heb05);
      `CHK("src", {1'b1, 12'h045}, {mem_rd_en, mem_rd_addr})
      issue(16'hf123);
      `CHK("dst", {1'b1, 12'h123, 8'h5a}, {mem_wr_en, mem_wr_addr, mem_wr_data})
      issue(16'heb85);
      issue(16'hf006);
      `CHK("idx dst", {1'b1, 12'h046}, {mem_wr_en, mem_wr_addr})
      issue(16'heb05);
      issue(16'hfff9);
      `CHK("barred", 1'b0, mem_wr_en)
      // Walk the frame pointer down so a source lands on an indirect register
      issue(16'he9bf);
      issue(16'he9bf);
      `CHK("frame sub", 12'hfc2, stack_frame_pointer)
      issue(16'heb25);
      `CHK("ind src", {1'b0, 12'hfe7}, {mem_rd_en, mem_rd_addr})
      issue(16'hf200);
      `CHK("ind data", {1'b1, 12'h200, 8'h00}, {mem_wr_en, mem_wr_addr, mem_wr_data})
   endtask
   task automatic report_and_stop;
      $display("TB: checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      t_ptr();
      t_ret();
      t_call();
      t_move();
      report_and_stop();
   end
endmodule // xie_exec_tb_top
